/* hdl/btg_pkg.sv */
package btg_pkg;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LEFT_CTRL  = 8'h47;
  localparam logic [7:0] ADDR_RIGHT_CTRL = 8'h48;
  localparam logic [7:0] ADDR_LEN_HIGH   = 8'h49;
  localparam logic [7:0] ADDR_LEN_MID    = 8'h4A;
  localparam logic [7:0] ADDR_LEN_LOW    = 8'h4B;
  localparam logic [7:0] ADDR_SIN_HIGH   = 8'h4C;
  localparam logic [7:0] ADDR_SIN_LOW    = 8'h4D;
  localparam logic [7:0] ADDR_COS_HIGH   = 8'h4E;
  localparam logic [7:0] ADDR_COS_LOW    = 8'h4F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LEFT_CTRL   = 8'h00;
  localparam logic [7:0] RST_RIGHT_CTRL  = 8'h00;
  localparam logic [7:0] RST_LEN_HIGH    = 8'h00;
  localparam logic [7:0] RST_LEN_MID     = 8'h00;
  localparam logic [7:0] RST_LEN_LOW     = 8'hEE;
  localparam logic [7:0] RST_SIN_HIGH    = 8'h10;
  localparam logic [7:0] RST_SIN_LOW     = 8'hD8;
  localparam logic [7:0] RST_COS_HIGH    = 8'h7E;
  localparam logic [7:0] RST_COS_LOW     = 8'hE3;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int         CTRL_EN_BIT     = 7;
  localparam int         VOL_MSB         = 5;
  localparam int         LINK_MSB        = 7;
  localparam int         LINK_LSB        = 6;
  localparam logic [1:0] LINK_R2L        = 2'h1;
  localparam logic [1:0] LINK_L2R        = 2'h2;
  localparam logic [5:0] VOL_UNITY       = 6'h02;
  localparam logic [4:0] playback_processing_block_25 = 5'h19;

  // ----------------------------------------------------------------
  // Arithmetic formats
  // ----------------------------------------------------------------
  localparam int         COS_SHIFT       = 14;  // 2*cos in Q2.14
  localparam int         GAIN_FRAC       = 14;
  localparam int         DB_PER_SHIFT    = 6;
  localparam logic [23:0] LEN_ONE        = 24'h000001;

  // ----------------------------------------------------------------
  // Sample rate divider
  // ----------------------------------------------------------------
  localparam int         SYS_CLK_HZ      = 125_000_000;
  localparam int         DAC_RATE_HZ     = 48_000;
  localparam int         DAC_DIV         = SYS_CLK_HZ / DAC_RATE_HZ;
  localparam logic [11:0] DAC_DIV_LAST   = 12'(DAC_DIV - 1);

  typedef enum logic [0:0] {
    BTG_IDLE = 1'b0,
    BTG_RUN  = 1'b1
  } btg_state_t;

endpackage

/* hdl/btg_osc.sv */
`timescale 1ns/100ps
module btg_osc
  import btg_pkg::*;
(
  input  wire logic               clk_sys_i,
  input  wire logic               reset_n_i,
  input  wire logic               start_i,
  input  wire logic               step_i,
  input  wire logic signed [15:0] sin_coef_i,
  input  wire logic signed [15:0] cos_coef_i,
  output logic signed [15:0]      sample_o
);

  logic signed [15:0] s1;
  logic signed [31:0] prod;
  logic signed [31:0] next_s1;

  // Two-term recursion: y[n+1] = 2cos(w) y[n] - y[n-1]
  always_comb
  begin
    prod    = 32'(cos_coef_i) * 32'(s1);
    next_s1 = (prod >>> COS_SHIFT) - 32'(sample_o);
  end

  // Start from y[0]=0, y[1]=sin(w); truncation may drift on very
  // long tones, a limitation traded for a multiplier-only datapath
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      sample_o <= '0;
      s1       <= '0;
    end
    else if (start_i)
    begin
      sample_o <= '0; // RQ6
      s1       <= sin_coef_i; // RQ6
    end
    else if (step_i)
    begin
      sample_o <= s1; // RQ10
      s1       <= next_s1[15:0]; // RQ9
    end
  end

endmodule // btg_osc

/* hdl/btg_vol.sv */
`timescale 1ns/100ps
module btg_vol
  import btg_pkg::*;
(
  input  wire logic               clk_sys_i,
  input  wire logic               reset_n_i,
  input  wire logic               step_i,
  input  wire logic [5:0]         code_i,
  input  wire logic signed [15:0] sample_i,
  output logic signed [15:0]      sample_o
);

  logic [5:0]         octave;
  logic [5:0]         fine;
  logic signed [15:0] mant;
  logic signed [31:0] prod;
  logic signed [31:0] scaled;

  // Code n is 2-n dB: a 6 dB octave shift plus a fine mantissa
  always_comb
  begin
    octave = code_i / 6'(DB_PER_SHIFT);
    fine   = code_i % 6'(DB_PER_SHIFT);
    case (fine)
      6'h00:   mant = 16'sh5092; // +2 dB
      6'h01:   mant = 16'sh47CF; // +1 dB
      6'h02:   mant = 16'sh4000; //  0 dB
      6'h03:   mant = 16'sh390A; // -1 dB
      6'h04:   mant = 16'sh32D6; // -2 dB
      default: mant = 16'sh2D4F; // -3 dB
    endcase
    prod   = 32'(sample_i) * 32'(mant);
    scaled = prod >>> (GAIN_FRAC + int'(octave));
  end

  // Gain above unity can exceed full scale, so saturate
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      sample_o <= '0;
    else if (step_i)
    begin
      if (scaled > 32'sd32767)
        sample_o <= 16'sh7FFF; // RQ2
      else if (scaled < -32'sd32768)
        sample_o <= 16'sh8000; // RQ2
      else
        sample_o <= scaled[15:0]; // RQ3
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  property p_unity;
    step_i && code_i == VOL_UNITY |=> sample_o == $past(sample_i);
  endproperty
  a_unity: assert property (p_unity) // RQ2
    else $error("unity code changed the sample");

  property p_hold;
    !step_i |=> $stable(sample_o);
  endproperty
  a_hold: assert property (p_hold) // RQ3
    else $error("volume output moved without a sample step");

endmodule // btg_vol

/* hdl/btg_tone_gen.sv */
`timescale 1ns/100ps
//
// Function
// [RQ1] Writing enable 1 starts the tone; it self-clears at end; writing 0 stops.
// [RQ2] Left volume code n gives 2-n dB, 1 dB steps, down to -61 dB.
// [RQ3] Right volume uses the same 1 dB step encoding as the left.
// [RQ4] Link 01: left uses right volume; 10: right uses left; else independent.
// [RQ5] Tone lasts the 24-bit sample count; low byte resets to EE.
// [RQ6] Sine coefficient, two bytes, resets to 10D8, seeds the oscillator.
// [RQ7] Tone is produced only when playback uses processing block 25.
// [RQ8] Software writes only the reset value into reserved control bit 6.
// [RQ9] Cosine coefficient, two bytes, resets to 7EE3, drives the recursion.
// [RQ10] Each sample while enabled: step oscillator, count down, clear at zero.
//
module btg_tone_gen
  import btg_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  input  wire logic [4:0]  playback_block_i,
  output logic [15:0]      tone_left_o,
  output logic [15:0]      tone_right_o,
  output logic             tone_valid_o,
  output logic             tone_active_o
);

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [6:0]  left_tone_control;
  logic [7:0]  right_tone_control;
  logic [7:0]  tone_length_high;
  logic [7:0]  tone_length_middle;
  logic [7:0]  tone_length_low;
  logic [7:0]  tone_sine_coef_high;
  logic [7:0]  tone_sine_coef_low;
  logic [7:0]  tone_cos_coef_high;
  logic [7:0]  tone_cos_coef_low;

  btg_state_t  state;
  logic [23:0] remaining;
  logic [11:0] div_cnt;
  logic        tick;
  logic        in_mode;
  logic        step;
  logic        ctrl_wr;
  logic        start;
  logic        last;
  logic [23:0] length;
  logic [5:0]  gain_code [2];
  logic signed [15:0] osc_sample;
  logic signed [15:0] chan_out [2];

  assign ctrl_wr = reg_wr_i && reg_addr_i == ADDR_LEFT_CTRL;
  assign start   = ctrl_wr && reg_wdata_i[CTRL_EN_BIT];
  assign length  = {tone_length_high, tone_length_middle, tone_length_low};
  assign in_mode = playback_block_i == playback_processing_block_25;
  assign step    = tick && state == BTG_RUN && in_mode; // RQ7
  assign last    = remaining <= LEN_ONE;

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      left_tone_control   <= RST_LEFT_CTRL[6:0];
      right_tone_control  <= RST_RIGHT_CTRL;
      tone_length_high    <= RST_LEN_HIGH;
      tone_length_middle  <= RST_LEN_MID;
      tone_length_low     <= RST_LEN_LOW; // RQ5
      tone_sine_coef_high <= RST_SIN_HIGH; // RQ6
      tone_sine_coef_low  <= RST_SIN_LOW; // RQ6
      tone_cos_coef_high  <= RST_COS_HIGH; // RQ9
      tone_cos_coef_low   <= RST_COS_LOW; // RQ9
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        // Bit 6 is stored as written; software keeps it at zero
        ADDR_LEFT_CTRL:  left_tone_control   <= reg_wdata_i[6:0]; // RQ8
        ADDR_RIGHT_CTRL: right_tone_control  <= reg_wdata_i;
        ADDR_LEN_HIGH:   tone_length_high    <= reg_wdata_i;
        ADDR_LEN_MID:    tone_length_middle  <= reg_wdata_i;
        ADDR_LEN_LOW:    tone_length_low     <= reg_wdata_i;
        ADDR_SIN_HIGH:   tone_sine_coef_high <= reg_wdata_i;
        ADDR_SIN_LOW:    tone_sine_coef_low  <= reg_wdata_i;
        ADDR_COS_HIGH:   tone_cos_coef_high  <= reg_wdata_i;
        ADDR_COS_LOW:    tone_cos_coef_low   <= reg_wdata_i;
        default:         ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= READ_UNMAPPED;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_LEFT_CTRL:  reg_rdata_o <= {state == BTG_RUN,
                                         left_tone_control}; // RQ1
        ADDR_RIGHT_CTRL: reg_rdata_o <= right_tone_control;
        ADDR_LEN_HIGH:   reg_rdata_o <= tone_length_high;
        ADDR_LEN_MID:    reg_rdata_o <= tone_length_middle;
        ADDR_LEN_LOW:    reg_rdata_o <= tone_length_low;
        ADDR_SIN_HIGH:   reg_rdata_o <= tone_sine_coef_high;
        ADDR_SIN_LOW:    reg_rdata_o <= tone_sine_coef_low;
        ADDR_COS_HIGH:   reg_rdata_o <= tone_cos_coef_high;
        ADDR_COS_LOW:    reg_rdata_o <= tone_cos_coef_low;
        default:         reg_rdata_o <= READ_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // DAC sample rate enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      div_cnt <= '0;
    else if (div_cnt == DAC_DIV_LAST)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 12'h001;
  end

  assign tick = div_cnt == DAC_DIV_LAST;

  // ----------------------------------------------------------------
  // Tone sequencing
  // ----------------------------------------------------------------
  // A software write wins over the self-clear in the same cycle, so a
  // restart issued just as a tone ends is never lost
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      state <= BTG_IDLE;
    else if (ctrl_wr)
      state <= reg_wdata_i[CTRL_EN_BIT] ? BTG_RUN : BTG_IDLE; // RQ1
    else
    begin
      case (state)
        BTG_IDLE: state <= BTG_IDLE;
        BTG_RUN:
          if (step && last)
            state <= BTG_IDLE; // RQ1
        default:  state <= BTG_IDLE;
      endcase
    end
  end

  // Outside block 25 the count is frozen, not lost
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      remaining <= '0;
    else if (start)
      remaining <= length; // RQ5
    else if (step && !last)
      remaining <= remaining - LEN_ONE; // RQ10
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      tone_valid_o <= 1'b0;
    else
      tone_valid_o <= step; // RQ7
  end

  assign tone_active_o = state == BTG_RUN;

  // ----------------------------------------------------------------
  // Volume linking and datapath
  // ----------------------------------------------------------------
  always_comb
  begin
    case (right_tone_control[LINK_MSB:LINK_LSB])
      LINK_R2L:
      begin
        gain_code[0] = right_tone_control[VOL_MSB:0]; // RQ4
        gain_code[1] = right_tone_control[VOL_MSB:0];
      end
      LINK_L2R:
      begin
        gain_code[0] = left_tone_control[VOL_MSB:0];
        gain_code[1] = left_tone_control[VOL_MSB:0]; // RQ4
      end
      default:
      begin
        gain_code[0] = left_tone_control[VOL_MSB:0];
        gain_code[1] = right_tone_control[VOL_MSB:0];
      end
    endcase
  end

  btg_osc u_osc (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .start_i    (start),
    .step_i     (step),
    .sin_coef_i ({tone_sine_coef_high, tone_sine_coef_low}),
    .cos_coef_i ({tone_cos_coef_high, tone_cos_coef_low}),
    .sample_o   (osc_sample)
  );

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    btg_vol u_vol (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .step_i    (step),
      .code_i    (gain_code[ch]),
      .sample_i  (osc_sample),
      .sample_o  (chan_out[ch])
    );
  end

  assign tone_left_o  = chan_out[0];
  assign tone_right_o = chan_out[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_start;
    ctrl_wr && reg_wdata_i[CTRL_EN_BIT];
  endsequence

  sequence s_loaded;
    tone_active_o && remaining == $past(length);
  endsequence

  property p_start;
    s_start |=> s_loaded;
  endproperty
  a_start: assert property (p_start) // RQ5
    else $error("start did not load the tone length");

  property p_stop;
    ctrl_wr && !reg_wdata_i[CTRL_EN_BIT] |=> !tone_active_o;
  endproperty
  a_stop: assert property (p_stop) // RQ1
    else $error("writing zero did not stop the tone");

  property p_count;
    step && !last && !ctrl_wr |=> remaining == $past(remaining) - LEN_ONE;
  endproperty
  a_count: assert property (p_count) // RQ10
    else $error("sample count did not step down by one");

  property p_end;
    // A restart taken on the very next edge is legal and re-raises active
    step && last && !ctrl_wr |=> !tone_active_o
      ##1 ($past(start) || !tone_active_o);
  endproperty
  a_end: assert property (p_end) // RQ1
    else $error("enable did not self-clear at the end");

  property p_mode;
    !in_mode |=> !tone_valid_o;
  endproperty
  a_mode: assert property (p_mode) // RQ7
    else $error("tone produced outside block 25");

  property p_link_r2l;
    right_tone_control[LINK_MSB:LINK_LSB] == LINK_R2L
      |-> gain_code[0] == right_tone_control[VOL_MSB:0];
  endproperty
  a_link_r2l: assert property (p_link_r2l) // RQ4
    else $error("left channel not linked to right volume");

  property p_link_l2r;
    right_tone_control[LINK_MSB:LINK_LSB] == LINK_L2R
      |-> gain_code[1] == left_tone_control[VOL_MSB:0];
  endproperty
  a_link_l2r: assert property (p_link_l2r) // RQ4
    else $error("right channel not linked to left volume");

  property p_seed;
    s_start |=> osc_sample == 16'sh0000
      && u_osc.s1 == $past({tone_sine_coef_high, tone_sine_coef_low});
  endproperty
  a_seed: assert property (p_seed) // RQ6
    else $error("oscillator not reseeded on start");

  property p_reset_coef;
    $rose(reset_n_i) |-> tone_sine_coef_high == RST_SIN_HIGH
      && tone_cos_coef_low == RST_COS_LOW && tone_length_low == RST_LEN_LOW;
  endproperty
  a_reset_coef: assert property (disable iff (1'b0) p_reset_coef) // RQ9
    else $error("coefficient reset values wrong");

endmodule // btg_tone_gen

/* tb/btg_tone_gen_tb.sv */
`timescale 1ns/100ps
module testbench
  import btg_pkg::*;
;
  logic        clk_sys_i;
  logic        reset_n_i;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic [4:0]  playback_block_i;
  logic [15:0] tone_left_o;
  logic [15:0] tone_right_o;
  logic        tone_valid_o;
  logic        tone_active_o;
  int          fail_count;
  int          n_tests;
  int          n_valid;
  logic [15:0] s_l;
  logic [15:0] s_r;
  logic [15:0] s_l3;
  logic [7:0]  addrs [9];
  logic [7:0]  rsts  [9];

  btg_tone_gen dut (
    .clk_sys_i        (clk_sys_i),
    .reset_n_i        (reset_n_i),
    .reg_addr_i       (reg_addr_i),
    .reg_wdata_i      (reg_wdata_i),
    .reg_wr_i         (reg_wr_i),
    .reg_rd_i         (reg_rd_i),
    .reg_rdata_o      (reg_rdata_o),
    .playback_block_i (playback_block_i),
    .tone_left_o      (tone_left_o),
    .tone_right_o     (tone_right_o),
    .tone_valid_o     (tone_valid_o),
    .tone_active_o    (tone_active_o)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------------------------------
  // Checks and register access
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Gain steps are approximate, so scaled samples are checked in a band
  task automatic chk_rng(input string what, input int lo, input int hi,
                         input logic [15:0] got);
    n_tests++;
    if ((^got === 1'bx) || $signed(got) < lo || $signed(got) > hi)
    begin
      fail_count++;
      $display("unexpected %s: expected %0d..%0d seen %h", what, lo, hi,
               got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i    = 1'b0;
    // Idle edge so a following call never re-raises the strobe at once
    @(negedge clk_sys_i);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i   = 1'b0;
    @(negedge clk_sys_i);
    chk(what, {8'h00, exp}, {8'h00, reg_rdata_o});
  endtask

  // Plays one tone and captures the samples after the leading zero
  task automatic tone(input logic [7:0] lc, input logic [7:0] rc,
                      input int len);
    int n;
    int t_prev;
    int bound;
    n       = 0;
    t_prev  = -1;
    n_valid = 0;
    bound   = (len + 1) * DAC_DIV + 10;
    wr(ADDR_RIGHT_CTRL, rc);
    wr(ADDR_LEFT_CTRL, 8'h80 | lc);
    chk("active after start", 16'h0001, {15'h0000, tone_active_o});
    do
    begin
      @(negedge clk_sys_i);
      n++;
      if (tone_valid_o === 1'b1)
      begin
        if (n_valid == 0)
          chk("first left", 16'h0000, tone_left_o);
        if (n_valid == 1)
        begin
          s_l = tone_left_o;
          s_r = tone_right_o;
        end
        if (n_valid == 2)
          s_l3 = tone_left_o;
        if (t_prev >= 0)
          chk("valid spacing", 16'(DAC_DIV), 16'(n - t_prev));
        t_prev = n;
        n_valid++;
      end
    end while (tone_active_o === 1'b1 && n < bound);
    if (n >= bound)
    begin
      fail_count++;
      $display("unexpected tone end: expected inactive seen active");
      final_report();
    end
    chk("valid count", 16'(len), 16'(n_valid));
    rd_chk("enable cleared", ADDR_LEFT_CTRL, lc);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    fail_count       = 0;
    n_tests          = 0;
    reset_n_i        = 1'b0;
    reg_addr_i       = 8'h00;
    reg_wdata_i      = 8'h00;
    reg_wr_i         = 1'b0;
    reg_rd_i         = 1'b0;
    playback_block_i = playback_processing_block_25;
    addrs = '{ADDR_LEFT_CTRL, ADDR_RIGHT_CTRL, ADDR_LEN_HIGH, ADDR_LEN_MID,
              ADDR_LEN_LOW, ADDR_SIN_HIGH, ADDR_SIN_LOW, ADDR_COS_HIGH,
              ADDR_COS_LOW};
    rsts  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hEE, 8'h10, 8'hD8, 8'h7E,
              8'hE3};
    repeat (12) @(negedge clk_sys_i);
    reset_n_i = 1'b1;

    chk("active at reset", 16'h0000, {15'h0000, tone_active_o});
    chk("left at reset", 16'h0000, tone_left_o);
    for (int i = 0; i < 9; i++)
      rd_chk("reset value", addrs[i], rsts[i]);
    wr(8'h50, 8'h5A);
    rd_chk("unmapped above", 8'h50, 8'h00);
    wr(8'h46, 8'h5A);
    rd_chk("unmapped below", 8'h46, 8'h00);
    $display("test reset_values done");

    // Reserved bit 6 of the left control is always written as zero
    wr(ADDR_LEFT_CTRL, 8'h15);
    rd_chk("left vol readback", ADDR_LEFT_CTRL, 8'h15);
    wr(ADDR_LEFT_CTRL, 8'h00);
    for (int i = 1; i < 9; i++)
    begin
      wr(addrs[i], ~rsts[i]);
      rd_chk("readback", addrs[i], ~rsts[i]);
      wr(addrs[i], rsts[i]);
    end
    $display("test readback done");

    wr(ADDR_LEN_LOW, 8'h03);
    tone(8'h02, 8'h00, 3);
    chk("left unity sine", 16'h10D8, s_l);
    chk_rng("right plus 2 dB", 5250, 5600, s_r);
    chk_rng("left third", 8500, 8600, s_l3);
    $display("test independent done");

    wr(ADDR_LEN_LOW, 8'h02);
    tone(8'h03, 8'hFF, 2);
    chk_rng("left minus 1 dB", 3700, 3950, s_l);
    chk_rng("right minus 61 dB", -8, 8, s_r);
    $display("test link_11 done");

    wr(ADDR_SIN_HIGH, 8'h20);
    wr(ADDR_SIN_LOW, 8'h00);
    tone(8'h3F, 8'h42, 2);
    chk("left from right", 16'h2000, s_l);
    chk("right own", 16'h2000, s_r);
    tone(8'h02, 8'hBF, 2);
    chk("left own", 16'h2000, s_l);
    chk("right from left", 16'h2000, s_r);
    $display("test link_modes done");

    // Other processing block: enabled but silent, count frozen
    playback_block_i = 5'h18;
    wr(ADDR_LEFT_CTRL, 8'h82);
    n_valid = 0;
    repeat (DAC_DIV + 10)
    begin
      @(negedge clk_sys_i);
      if (tone_valid_o !== 1'b0)
        n_valid++;
    end
    chk("valid off block", 16'h0000, 16'(n_valid));
    chk("active held", 16'h0001, {15'h0000, tone_active_o});
    rd_chk("enable held", ADDR_LEFT_CTRL, 8'h82);
    wr(ADDR_LEFT_CTRL, 8'h02);
    chk("active stopped", 16'h0000, {15'h0000, tone_active_o});
    rd_chk("enable stopped", ADDR_LEFT_CTRL, 8'h02);
    playback_block_i = playback_processing_block_25;
    $display("test block_select done");

    final_report();
  end
endmodule // testbench
